// ==== verilog/sdcmd_cfg.svh ====
// constants for the sdram command and clock-enable decode pair
// assumes both ends share one clock; included by bare name
// Behaviour
// - cs low, others high decodes no-operation
// - no-operation never cuts a running burst
// - cs high acts as no-operation
// - controller holds clock enable high during access
// - clock enable low, bank active: clock suspend
// - suspend takes effect one clock later
// - commands discarded while suspended
// - suspend ends one clock after enable high
// - commands captured on rising edges only
// - current and previous enable samples select modes
// - read/write need active bank; A10 auto-precharge
// - burst stop only during full-page burst
// - no power down in burst; suspend instead
// - precharge: A10 low one bank, high both
// - self refresh held while enable low
// - controller sends no-operation after power-down exit
`ifndef SDCMD_CFG_SVH
`define SDCMD_CFG_SVH
`define SDCMD_ADDR_W       11
`define SDCMD_A10_POS      10
`define SDCMD_BURST_LEN    4
`define SDCMD_FULL_PAGE    256
`define SDCMD_CNT_W        9
`endif

// ==== verilog/sdcmd_pkg.sv ====
// types shared by the controller end and the device end
// assumes sdcmd_cfg.svh gives the numeric constants
`default_nettype none
package sdcmd_pkg;
    typedef enum logic [3:0] {
        SDCMD_NOP   = 4'h0,
        SDCMD_ACT   = 4'h1,
        SDCMD_RD    = 4'h2,
        SDCMD_WR    = 4'h3,
        SDCMD_PRE   = 4'h4,
        SDCMD_MRS   = 4'h5,
        SDCMD_REF   = 4'h6,
        SDCMD_SREF  = 4'h7,
        SDCMD_BSTOP = 4'h8
    } sdcmd_op_t;

    typedef enum logic [2:0] {
        SDCMD_S_NORMAL  = 3'h0,
        SDCMD_S_SUSPEND = 3'h1,
        SDCMD_S_PWRDN   = 3'h2,
        SDCMD_S_SELFREF = 3'h3
    } sdcmd_mode_t;
endpackage
`default_nettype wire

// ==== verilog/sdcmd_if.sv ====
// command pins between a memory controller and the sdram decode
// assumes one shared clock on both ends
`timescale 1ns/1ps
`default_nettype none
`include "sdcmd_cfg.svh"
interface sdcmd_if;
    logic                      cs_b;
    logic                      ras_b;
    logic                      cas_b;
    logic                      we_b;
    logic                      bank_sel;
    logic [`SDCMD_ADDR_W-1:0]  addr;
    logic                      clock_enable;

    modport ctrl (output cs_b, output ras_b, output cas_b, output we_b,
                  output bank_sel, output addr, output clock_enable);
    modport dev  (input cs_b, input ras_b, input cas_b, input we_b,
                  input bank_sel, input addr, input clock_enable);
endinterface
`default_nettype wire

// ==== verilog/sdcmd_ctrl.sv ====
// controller end: drives command pins from a user request
// assumes user holds req until ack; same clock as device end
`timescale 1ns/1ps
`default_nettype none
`include "sdcmd_cfg.svh"
module sdcmd_ctrl
(
    input  wire logic                     clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic                     req_in,
    input  wire sdcmd_pkg::sdcmd_op_t     op_in,
    input  wire logic                     bank_in,
    input  wire logic [`SDCMD_ADDR_W-1:0] addr_in,
    input  wire logic                     clock_enable_in,
    output logic                          ack_out,
    sdcmd_if.ctrl                         pins
);
    logic                     cs_b_r, ras_b_r, cas_b_r, we_b_r, bank_r, cke_r, ack_r;
    logic                     cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt, bank_nxt, cke_nxt, ack_nxt;
    logic [`SDCMD_ADDR_W-1:0] addr_r, addr_nxt;

    always_comb
    begin
        // idle cycles default to no-operation
        {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h7;
        bank_nxt = bank_r;
        addr_nxt = addr_r;
        cke_nxt  = clock_enable_in;
        ack_nxt  = 1'b0;
        // after a low enable sample only no-operation is sent
        if (req_in && !ack_r && cke_r && clock_enable_in)
        begin
            ack_nxt  = 1'b1;
            bank_nxt = bank_in;
            addr_nxt = addr_in;
            case (op_in)
                sdcmd_pkg::SDCMD_ACT:   {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h3;
                sdcmd_pkg::SDCMD_RD:    {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h5;
                sdcmd_pkg::SDCMD_WR:    {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h4;
                sdcmd_pkg::SDCMD_PRE:   {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h2;
                sdcmd_pkg::SDCMD_MRS:   {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h0;
                sdcmd_pkg::SDCMD_REF:   {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h1;
                sdcmd_pkg::SDCMD_SREF:
                begin
                    {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h1;
                    cke_nxt = 1'b0;
                end
                sdcmd_pkg::SDCMD_BSTOP: {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h6;
                default:                {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt} = 4'h7;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            {cs_b_r, ras_b_r, cas_b_r, we_b_r} <= 4'hF;
            bank_r <= 1'b0;
            addr_r <= '0;
            cke_r  <= 1'b1;
            ack_r  <= 1'b0;
        end
        else
        begin
            {cs_b_r, ras_b_r, cas_b_r, we_b_r} <= {cs_b_nxt, ras_b_nxt, cas_b_nxt, we_b_nxt};
            bank_r <= bank_nxt;
            addr_r <= addr_nxt;
            cke_r  <= cke_nxt;
            ack_r  <= ack_nxt;
        end
    end

    assign pins.cs_b         = cs_b_r;
    assign pins.ras_b        = ras_b_r;
    assign pins.cas_b        = cas_b_r;
    assign pins.we_b         = we_b_r;
    assign pins.bank_sel     = bank_r;
    assign pins.addr         = addr_r;
    assign pins.clock_enable = cke_r;
    assign ack_out           = ack_r;
endmodule
`default_nettype wire

// ==== verilog/sdcmd_dev.sv ====
// device end: decodes commands and clock-enable modes
// assumes pins come from logic on the same clock, so no synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "sdcmd_cfg.svh"
module sdcmd_dev
#(
    parameter int BURST_LEN = `SDCMD_BURST_LEN,
    parameter bit FULL_PAGE = 1'b0
)
(
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    sdcmd_if.dev                   pins,
    output logic [3:0]             cmd_out,
    output logic                   cmd_valid_out,
    output logic                   auto_pre_out,
    output logic [1:0]             bank_active_out,
    output logic                   burst_busy_out,
    output logic                   suspended_out,
    output logic [2:0]             mode_out,
    output logic                   illegal_out
);
    if (BURST_LEN < 1 || BURST_LEN > `SDCMD_FULL_PAGE)
    begin : g_bad_burst_len
        $error("burst length out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sdcmd_pkg::sdcmd_mode_t   mode_r, mode_nxt;
    logic                     cke_prev_r;
    logic [1:0]               act_r, act_nxt;
    logic [`SDCMD_CNT_W-1:0]  burst_r, burst_nxt;
    logic                     frozen_r, frozen_nxt;
    logic [3:0]               cmd_r, cmd_nxt;
    logic                     valid_r, valid_nxt, ap_r, ap_nxt, ill_r, ill_nxt;
    logic                     busy_r, busy_nxt;

    logic                     clock_enable_current_sample;
    logic                     clock_enable_previous_sample;
    logic                     deselect;
    logic [3:0]               pat;
    logic                     a10;

    assign clock_enable_current_sample  = pins.clock_enable;
    assign clock_enable_previous_sample = cke_prev_r;
    assign deselect = pins.cs_b;
    assign pat      = {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b};
    assign a10      = pins.addr[`SDCMD_A10_POS];

    // ------------------------------------------------------------
    // decode and mode update
    // ------------------------------------------------------------
    always_comb
    begin
        mode_nxt   = mode_r;
        act_nxt    = act_r;
        burst_nxt  = burst_r;
        frozen_nxt = frozen_r;
        cmd_nxt    = sdcmd_pkg::SDCMD_NOP;
        valid_nxt  = 1'b0;
        ap_nxt     = 1'b0;
        ill_nxt    = 1'b0;
        // burst advances only on running internal clock; suspend freezes it one clock late
        if (!frozen_r && burst_r != '0)
            burst_nxt = burst_r - `SDCMD_CNT_W'(1);
        case (mode_r)
            sdcmd_pkg::SDCMD_S_SUSPEND:
            begin
                // commands ignored; thaw one clock after enable high
                if (clock_enable_current_sample)
                begin
                    mode_nxt   = sdcmd_pkg::SDCMD_S_NORMAL;
                    frozen_nxt = 1'b0;
                end
                else
                    frozen_nxt = 1'b1;
            end
            sdcmd_pkg::SDCMD_S_PWRDN:
            begin
                if (clock_enable_current_sample &&
                    (deselect || pat[2:0] == 3'h7))
                    mode_nxt = sdcmd_pkg::SDCMD_S_NORMAL;
            end
            sdcmd_pkg::SDCMD_S_SELFREF:
            begin
                if (clock_enable_current_sample)
                    mode_nxt = sdcmd_pkg::SDCMD_S_NORMAL;
            end
            default:
            begin
                if (clock_enable_previous_sample)
                begin
                    if (!deselect && pat[2:0] == 3'h1 && !clock_enable_current_sample)
                    begin
                        // self-refresh entry needs idle banks
                        cmd_nxt   = sdcmd_pkg::SDCMD_SREF;
                        valid_nxt = 1'b1;
                        ill_nxt   = act_r != 2'h0;
                        mode_nxt  = sdcmd_pkg::SDCMD_S_SELFREF;
                    end
                    else
                    begin
                        if (!clock_enable_current_sample)
                        begin
                            if (act_r != 2'h0 || burst_r != '0)
                                mode_nxt = sdcmd_pkg::SDCMD_S_SUSPEND;
                            else
                                mode_nxt = sdcmd_pkg::SDCMD_S_PWRDN;
                        end
                        if (!deselect)
                        begin
                            valid_nxt = pat[2:0] != 3'h7;
                            case (pat[2:0])
                                3'h3:
                                begin
                                    cmd_nxt = sdcmd_pkg::SDCMD_ACT;
                                    ill_nxt = act_r[pins.bank_sel];
                                    act_nxt[pins.bank_sel] = 1'b1;
                                end
                                3'h5, 3'h4:
                                begin
                                    cmd_nxt   = (pat[0]) ? sdcmd_pkg::SDCMD_RD : sdcmd_pkg::SDCMD_WR;
                                    ap_nxt    = a10;
                                    ill_nxt   = !act_r[pins.bank_sel] || (a10 && FULL_PAGE);
                                    // a refused access must not start a burst or close a bank
                                    if (!ill_nxt)
                                    begin
                                        burst_nxt = FULL_PAGE ? `SDCMD_CNT_W'(`SDCMD_FULL_PAGE)
                                                              : `SDCMD_CNT_W'(BURST_LEN);
                                        if (a10)
                                            act_nxt[pins.bank_sel] = 1'b0;
                                    end
                                end
                                3'h2:
                                begin
                                    cmd_nxt = sdcmd_pkg::SDCMD_PRE;
                                    if (a10)
                                        act_nxt = 2'h0;
                                    else
                                        act_nxt[pins.bank_sel] = 1'b0;
                                end
                                3'h0:
                                begin
                                    cmd_nxt = sdcmd_pkg::SDCMD_MRS;
                                    ill_nxt = act_r != 2'h0;
                                end
                                3'h1:
                                begin
                                    cmd_nxt = sdcmd_pkg::SDCMD_REF;
                                    ill_nxt = act_r != 2'h0;
                                end
                                3'h6:
                                begin
                                    cmd_nxt = sdcmd_pkg::SDCMD_BSTOP;
                                    ill_nxt = !(FULL_PAGE && burst_r != '0);
                                    if (!ill_nxt)
                                        burst_nxt = '0;
                                end
                                default: cmd_nxt = sdcmd_pkg::SDCMD_NOP;
                            endcase
                        end
                    end
                end
            end
        endcase
        // refused commands clear the valid and auto-precharge flags but keep cmd_out
        if (ill_nxt)
        begin
            valid_nxt = 1'b0;
            ap_nxt    = 1'b0;
        end
        busy_nxt = burst_nxt != '0;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mode_r     <= sdcmd_pkg::SDCMD_S_NORMAL;
            cke_prev_r <= 1'b1;
            act_r      <= 2'h0;
            burst_r    <= '0;
            frozen_r   <= 1'b0;
            cmd_r      <= 4'h0;
            valid_r    <= 1'b0;
            ap_r       <= 1'b0;
            ill_r      <= 1'b0;
            busy_r     <= 1'b0;
        end
        else
        begin
            mode_r     <= mode_nxt;
            cke_prev_r <= clock_enable_current_sample;
            act_r      <= act_nxt;
            burst_r    <= burst_nxt;
            frozen_r   <= frozen_nxt;
            cmd_r      <= cmd_nxt;
            valid_r    <= valid_nxt;
            ap_r       <= ap_nxt;
            ill_r      <= ill_nxt;
            busy_r     <= busy_nxt;
        end
    end

    assign cmd_out         = cmd_r;
    assign cmd_valid_out   = valid_r;
    assign auto_pre_out    = ap_r;
    assign bank_active_out = act_r;
    assign burst_busy_out  = busy_r;
    assign suspended_out   = frozen_r;
    assign mode_out        = mode_r;
    assign illegal_out     = ill_r;
endmodule
`default_nettype wire

// ==== verif/sdcmd_props.sv ====
// assertions on the command pins and the device end's decode outputs
// assumes one clock and an async active-low reset shared by both ends
`timescale 1ns/1ps
`default_nettype none
`include "sdcmd_cfg.svh"
module sdcmd_props
(
    input wire logic                     clk_in,
    input wire logic                     rst_b_in,
    input wire logic                     cs_b,
    input wire logic                     ras_b,
    input wire logic                     cas_b,
    input wire logic                     we_b,
    input wire logic                     bank_sel,
    input wire logic [`SDCMD_ADDR_W-1:0] addr,
    input wire logic                     clock_enable,
    input wire logic [3:0]               cmd_out,
    input wire logic                     cmd_valid_out,
    input wire logic                     auto_pre_out,
    input wire logic [1:0]               bank_active_out,
    input wire logic                     burst_busy_out,
    input wire logic                     suspended_out,
    input wire logic [2:0]               mode_out
);
    localparam logic [2:0] NRM = sdcmd_pkg::SDCMD_S_NORMAL;
    localparam logic [2:0] SUS = sdcmd_pkg::SDCMD_S_SUSPEND;
    localparam logic [2:0] PWD = sdcmd_pkg::SDCMD_S_PWRDN;
    localparam logic [2:0] SRF = sdcmd_pkg::SDCMD_S_SELFREF;
    // ----------------
    // helper state
    // ----------------
    logic       prev_ce_r;
    logic       prev_ce_nxt;
    logic [3:0] pat;
    logic       live;
    logic       quiet;
    always_comb
    begin
        prev_ce_nxt = clock_enable;
        pat         = {cs_b, ras_b, cas_b, we_b};
        live        = prev_ce_r && (mode_out == NRM);
        // mode entries are only judged on edges without a command
        quiet       = cs_b || (pat == 4'h7);
    end
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            prev_ce_r <= 1'b1;
        else
            prev_ce_r <= prev_ce_nxt;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // ----------------
    // properties
    // ----------------
    chk_desel_quiet: assert property (cs_b |=> !cmd_valid_out)
        else $error("deselect produced a command");
    chk_act_decode: assert property (live && pat == 4'h3 && !bank_active_out[bank_sel]
        |=> cmd_valid_out && cmd_out == 4'h1 && bank_active_out[$past(bank_sel)])
        else $error("activate not decoded");
    chk_read_autopre: assert property (live && pat == 4'h5 && bank_active_out[bank_sel]
        |=> cmd_valid_out && cmd_out == 4'h2 && auto_pre_out == $past(addr[`SDCMD_A10_POS]))
        else $error("read or its auto-precharge flag wrong");
    chk_idle_access: assert property (live && pat[3:1] == 3'h2 && !bank_active_out[bank_sel]
        |=> !cmd_valid_out)
        else $error("access to idle bank accepted");
    chk_susp_entry: assert property (live && !clock_enable && quiet && (bank_active_out != 2'h0 || burst_busy_out)
        |=> mode_out == SUS && !suspended_out)
        else $error("clock suspend entry wrong");
    chk_susp_freeze: assert property ($rose(mode_out == SUS) && !clock_enable |=> suspended_out)
        else $error("suspend did not freeze one clock later");
    chk_susp_exit: assert property (mode_out == SUS && clock_enable |=> mode_out == NRM && !suspended_out)
        else $error("clock suspend exit wrong");
    chk_mode_mute: assert property (mode_out != NRM |=> !cmd_valid_out)
        else $error("command accepted outside normal mode");
    chk_pd_entry: assert property (live && !clock_enable && quiet && bank_active_out == 2'h0 && !burst_busy_out
        |=> mode_out == PWD)
        else $error("power down entry wrong");
    chk_sref_hold: assert property (mode_out == SRF && !clock_enable |=> mode_out == SRF)
        else $error("self refresh left while enable low");
    chk_exit_nop: assert property ($rose(clock_enable) |-> cs_b || pat == 4'h7)
        else $error("command sent on the edge where enable returned");
    chk_access_ce: assert property (!cs_b && pat[2:1] != 2'h0 && pat[2:0] != 3'h7 |-> clock_enable)
        else $error("access command sent with enable low");
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// bench: controller and device ends joined by one interface, plus a device
// end driven straight from the bench; assumes design files compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sdcmd_cfg.svh"
module tb_top;
    logic                     clk_in;
    logic                     rst_b_in;
    logic                     req_in;
    sdcmd_pkg::sdcmd_op_t     op_in;
    logic                     bank_in;
    logic [`SDCMD_ADDR_W-1:0] addr_in;
    logic                     ce_in;
    logic                     ack_out;
    logic [3:0]               cmd_out;
    logic                     cmd_valid_out;
    logic                     auto_pre_out;
    logic [1:0]               bank_active_out;
    logic                     burst_busy_out;
    logic                     suspended_out;
    logic [2:0]               mode_out;
    logic                     illegal_out;
    logic                     b_valid;
    logic [1:0]               b_bank;
    int                       fails;
    int                       tests_run;
    sdcmd_if ifa();
    sdcmd_if ifb();
    sdcmd_ctrl sdcmd_ctrl_inst(.clk_in, .rst_b_in, .req_in, .op_in, .bank_in, .addr_in,
        .clock_enable_in(ce_in), .ack_out, .pins(ifa));
    sdcmd_dev sdcmd_dev_inst(.clk_in, .rst_b_in, .pins(ifa), .cmd_out, .cmd_valid_out, .auto_pre_out,
        .bank_active_out, .burst_busy_out, .suspended_out, .mode_out, .illegal_out);
    // second device end lets the bench break the pin rules on purpose
    sdcmd_dev sdcmd_dev_inst_b(.clk_in, .rst_b_in, .pins(ifb), .cmd_out(), .cmd_valid_out(b_valid),
        .auto_pre_out(), .bank_active_out(b_bank), .burst_busy_out(), .suspended_out(), .mode_out(),
        .illegal_out());
    sdcmd_props sdcmd_props_inst(.clk_in, .rst_b_in, .cs_b(ifa.cs_b), .ras_b(ifa.ras_b), .cas_b(ifa.cas_b),
        .we_b(ifa.we_b), .bank_sel(ifa.bank_sel), .addr(ifa.addr), .clock_enable(ifa.clock_enable),
        .cmd_out, .cmd_valid_out, .auto_pre_out, .bank_active_out, .burst_busy_out, .suspended_out, .mode_out);
    // ----------------
    // tasks
    // ----------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [3:0] o, input logic b, input logic a10, input logic ill);
        int   n;
        logic ap;
        n  = 0;
        ap = !ill && a10 && (o == 4'h2 || o == 4'h3);
        @(posedge clk_in);
        req_in  <= 1'b1;
        op_in   <= sdcmd_pkg::sdcmd_op_t'(o);
        bank_in <= b;
        addr_in <= {a10, 10'h0A5};
        @(posedge clk_in);
        // self refresh needs the enable kept low after the entry edge
        if (o == 4'h7)
            ce_in <= 1'b0;
        do
        begin
            @(negedge clk_in);
            n++;
        end
        while (ack_out !== 1'b1 && n < 20);
        chk(ack_out, 8'h01);
        @(posedge clk_in);
        req_in <= 1'b0;
        @(negedge clk_in);
        if (o != 4'h7)
            chk({illegal_out, auto_pre_out, cmd_valid_out, cmd_valid_out ? cmd_out : 4'h0},
                {ill, ap, !ill, ill ? 4'h0 : o});
    endtask
    task automatic wmode(input logic [2:0] m);
        int n;
        n = 0;
        while (mode_out !== m && n < 10)
        begin
            @(negedge clk_in);
            n++;
        end
        chk(mode_out, m);
    endtask
    task automatic set_ce(input logic v);
        @(posedge clk_in);
        ce_in <= v;
    endtask
    task automatic pb(input logic [3:0] p, input logic ce);
        @(posedge clk_in);
        {ifb.cs_b, ifb.ras_b, ifb.cas_b, ifb.we_b} <= p;
        ifb.clock_enable <= ce;
    endtask
    // ----------------
    // stimulus
    // ----------------
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial
    begin
        #75000;
        $display("Error at %0t: watchdog expired got %h expected %h", $time, 1'b0, 1'b1);
        fails++;
        end_of_test();
    end
    initial
    begin
        fails = 0;
        tests_run = 0;
        rst_b_in = 1'b0;
        {req_in, bank_in, addr_in, ce_in} = {1'b0, 1'b0, 11'h000, 1'b1};
        op_in = sdcmd_pkg::SDCMD_NOP;
        {ifb.cs_b, ifb.ras_b, ifb.cas_b, ifb.we_b, ifb.clock_enable} = 5'h1F;
        {ifb.bank_sel, ifb.addr} = 12'h000;
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        op(4'h1, 1'b0, 1'b0, 1'b0);
        op(4'h2, 1'b0, 1'b0, 1'b0);
        @(negedge clk_in);
        chk(burst_busy_out, 8'h01);
        op(4'h3, 1'b1, 1'b0, 1'b1);
        op(4'h8, 1'b0, 1'b0, 1'b1);
        op(4'h5, 1'b0, 1'b0, 1'b1);
        op(4'h1, 1'b1, 1'b0, 1'b0);
        op(4'h3, 1'b1, 1'b1, 1'b0);
        op(4'h1, 1'b1, 1'b0, 1'b0);
        op(4'h4, 1'b0, 1'b0, 1'b0);
        chk(bank_active_out, 8'h02);
        set_ce(1'b0);
        wmode(sdcmd_pkg::SDCMD_S_SUSPEND);
        @(negedge clk_in);
        chk(suspended_out, 8'h01);
        set_ce(1'b1);
        wmode(sdcmd_pkg::SDCMD_S_NORMAL);
        chk(suspended_out, 8'h00);
        op(4'h4, 1'b0, 1'b1, 1'b0);
        chk(bank_active_out, 8'h00);
        op(4'h5, 1'b0, 1'b0, 1'b0);
        op(4'h6, 1'b0, 1'b0, 1'b0);
        set_ce(1'b0);
        wmode(sdcmd_pkg::SDCMD_S_PWRDN);
        set_ce(1'b1);
        wmode(sdcmd_pkg::SDCMD_S_NORMAL);
        op(4'h1, 1'b0, 1'b0, 1'b0);
        op(4'h2, 1'b0, 1'b1, 1'b0);
        set_ce(1'b0);
        wmode(sdcmd_pkg::SDCMD_S_SUSPEND);
        set_ce(1'b1);
        wmode(sdcmd_pkg::SDCMD_S_NORMAL);
        op(4'h7, 1'b0, 1'b0, 1'b0);
        wmode(sdcmd_pkg::SDCMD_S_SELFREF);
        repeat (5) @(negedge clk_in);
        chk(mode_out, sdcmd_pkg::SDCMD_S_SELFREF);
        set_ce(1'b1);
        wmode(sdcmd_pkg::SDCMD_S_NORMAL);
        pb(4'hB, 1'b1);
        pb(4'hF, 1'b1);
        @(negedge clk_in);
        chk({b_valid, b_bank}, 8'h00);
        pb(4'h3, 1'b1);
        pb(4'h7, 1'b1);
        @(negedge clk_in);
        chk({b_valid, b_bank}, 8'h05);
        @(negedge clk_in);
        chk(b_valid, 8'h00);
        repeat (3) pb(4'h7, 1'b0);
        pb(4'h5, 1'b0);
        pb(4'h7, 1'b0);
        @(negedge clk_in);
        chk(b_valid, 8'h00);
        pb(4'h5, 1'b1);
        pb(4'h7, 1'b1);
        @(negedge clk_in);
        chk(b_valid, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
